/* File: rtl/port2_pkg.sv */
package port2_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NLINES = 16;
  localparam int NFAST = 8;
  localparam int FAST_BASE = 8;
  localparam int T7_LINE = 15;
  localparam int MODE_W = 2;

  // ----------------------------------------------------------------
  // register offsets (16-bit word registers)
  // ----------------------------------------------------------------
  localparam logic [15:0] DATA_OFS = 16'hFFC0;
  localparam logic [15:0] DIR_OFS = 16'hFFC2;
  localparam logic [15:0] OD_OFS = 16'hF1C2;
  localparam logic [15:0] MODE_LO_OFS = 16'hF1D0;
  localparam logic [15:0] MODE_HI_OFS = 16'hF1D2;
  localparam logic [15:0] STAT_OFS = 16'hF1D4;
  localparam logic [15:0] MASK_OFS = 16'hF1D6;
  localparam logic [15:0] FSTAT_OFS = 16'hF1D8;
  localparam logic [15:0] FMASK_OFS = 16'hF1DA;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // compare modes, two bits per line
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CMP_OFF = 2'h0,
    CMP_TOGGLE = 2'h1,
    CMP_DOUBLE = 2'h2,
    CMP_SET_CLR = 2'h3
  } cmp_mode_t;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SLOW_SAMPLE_NS = 200;
  localparam int FAST_SAMPLE_NS = 25;
  // sample periods are longest times, so round down
  localparam int SLOW_SAMPLE_CYC = SLOW_SAMPLE_NS * 1000 / CLK_PERIOD_PS;
  localparam int FAST_SAMPLE_CYC = FAST_SAMPLE_NS * 1000 / CLK_PERIOD_PS;

endpackage : port2_pkg

/* File: rtl/line_sampler.sv */
module line_sampler #(
  parameter int W = 16,
  parameter int PERIOD = 50
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] smp,
  output logic [W-1:0] rise
);
  localparam int CW = $clog2(PERIOD + 1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic [W-1:0] next_smp;
  logic [W-1:0] next_rise;
  logic tick;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (PERIOD < 1 || W < 1) begin : g_bad
    $error("line_sampler: PERIOD and W must be at least 1");
  end

  // divider makes one enable pulse per sample period
  assign tick = (cnt == LAST);

  always_comb begin
    next_cnt = tick ? '0 : cnt + 1'b1;
    next_smp = tick ? d : smp;
    next_rise = tick ? (d & ~smp) : '0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      smp <= '0;
      rise <= '0;
    end else begin
      cnt <= next_cnt;
      smp <= next_smp;
      rise <= next_rise;
    end
  end

endmodule : line_sampler

/* File: rtl/line_cell.sv */
module line_cell (
  input wire logic clk,
  input wire logic rst,
  input wire logic cpu_wr,
  input wire logic cpu_bit,
  input wire logic cmp_trig,
  input wire logic alt_bit,
  input wire logic dir,
  input wire logic od,
  output logic q,
  output logic pin_o,
  output logic pin_oe
);
  logic next_q;

  // ----------------------------------------------------------------
  // output latch input multiplexer
  // ----------------------------------------------------------------
  // mux before latch
  always_comb begin
    if (cpu_wr) begin
      next_q = cpu_bit;
    end else if (cmp_trig) begin
      next_q = alt_bit;
    end else begin
      next_q = q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // pin driver
  // ----------------------------------------------------------------
  // direction drives pin
  assign pin_o = od ? 1'b0 : q;
  assign pin_oe = dir & ~(od & q);

endmodule : line_cell

/* File: rtl/port2_ccio.sv */
// Function
// - direction bit 0 makes line high-impedance input, 1 a driven output.
// - all sixteen lines serve as capture/compare channels, same index.
// - on input lines the capture signal comes from the input latch showing the pin.
// - output lines feed the output latch to capture, allowing soft captures.
// - compare mode 1 match inverts the output latch.
// - compare mode 3 match sets latch, timer overflow clears it.
// - hardware latch updates use compare trigger and alternate data.
// - compare output with input direction leaves pin high-impedance.
// - software always writes the latch; modes 1 and double toggle.
// - cpu write coinciding with compare trigger wins; trigger change lost.
// - capture lines double as interrupt inputs, sampled every 200 ns.
// - lines 8 to 15 are fast interrupt inputs 0 to 7, sampled every 24 ns.
// - top line pin level is timer seven external count input.
// - bus data and alternate data are muxed ahead of the latch.
// - each line selects push-pull or open-drain by its own bit.
module port2_ccio (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [15:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic [port2_pkg::NLINES-1:0] CAPTURE_COMPARE_CHANNEL_PINS_IN,
  output logic [port2_pkg::NLINES-1:0] CAPTURE_COMPARE_CHANNEL_PINS_OUT,
  output logic [port2_pkg::NLINES-1:0] CAPTURE_COMPARE_CHANNEL_PINS_OE,
  input wire logic [port2_pkg::NLINES-1:0] CMP_MATCH,
  input wire logic [port2_pkg::NLINES-1:0] TMR_OVF,
  output logic [port2_pkg::NLINES-1:0] CAP_IN,
  output logic [port2_pkg::NFAST-1:0] FAST_IRQ_INPUT,
  output logic TIMER_SEVEN_COUNT_INPUT,
  output logic IRQ
);
  import port2_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [NLINES-1:0] sync1;
  logic [NLINES-1:0] sync2;
  logic [NLINES-1:0] latch;
  logic [NLINES-1:0] trig;
  logic [NLINES-1:0] alt;
  logic [NLINES-1:0] cap_src;
  logic [NLINES-1:0] slow_rise;
  logic [NFAST-1:0] fast_rise;

  logic [15:0] line_direction_control;
  logic [15:0] line_open_drain_select;
  logic [2*NLINES-1:0] mode;
  logic [15:0] stat;
  logic [15:0] mask;
  logic [7:0] fstat;
  logic [7:0] fmask;

  logic [15:0] next_dir;
  logic [15:0] next_od;
  logic [2*NLINES-1:0] next_mode;
  logic [15:0] next_stat;
  logic [15:0] next_mask;
  logic [7:0] next_fstat;
  logic [7:0] next_fmask;
  logic [15:0] next_rdata;
  logic [NLINES-1:0] next_cap;
  logic next_t7;

  logic wr_data;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // pins are asynchronous; only sync2 is read by logic
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sync1 <= RST_WORD;
      sync2 <= RST_WORD;
    end else begin
      sync1 <= CAPTURE_COMPARE_CHANNEL_PINS_IN;
      sync2 <= sync1;
    end
  end

  // latch level for outputs
  // a driven pin would show the latch anyway, and reading the latch
  // directly avoids two cycles of synchroniser lag on soft captures
  assign cap_src = (line_direction_control & latch)
                 | (~line_direction_control & sync2);

  // ----------------------------------------------------------------
  // per-line compare logic and latch
  // ----------------------------------------------------------------
  assign wr_data = WR && (ADDR == DATA_OFS);

  for (genvar i = 0; i < NLINES; i++) begin : g_line
    cmp_mode_t m;
    logic alt_b;
    logic trig_b;

    assign m = cmp_mode_t'(mode[MODE_W*i +: MODE_W]);

    always_comb begin
      alt_b = 1'b0;
      trig_b = 1'b0;
      case (m)
        CMP_TOGGLE, CMP_DOUBLE: begin
          trig_b = CMP_MATCH[i];
          alt_b = ~latch[i];
        end
        CMP_SET_CLR: begin
          trig_b = CMP_MATCH[i] | TMR_OVF[i];
          alt_b = CMP_MATCH[i];
        end
        default: begin
          trig_b = 1'b0;
          alt_b = 1'b0;
        end
      endcase
    end

    assign trig[i] = trig_b;
    assign alt[i] = alt_b;

    line_cell u_cell (
      .clk(CLK),
      .rst(RST),
      .cpu_wr(wr_data),
      .cpu_bit(WDATA[i]),
      .cmp_trig(trig[i]),
      .alt_bit(alt[i]),
      .dir(line_direction_control[i]),
      .od(line_open_drain_select[i]),
      .q(latch[i]),
      .pin_o(CAPTURE_COMPARE_CHANNEL_PINS_OUT[i]),
      .pin_oe(CAPTURE_COMPARE_CHANNEL_PINS_OE[i])
    );
  end

  // ----------------------------------------------------------------
  // interrupt samplers
  // ----------------------------------------------------------------
  // slow capture sampling
  line_sampler #(
    .W(NLINES),
    .PERIOD(SLOW_SAMPLE_CYC)
  ) u_slow (
    .clk(CLK),
    .rst(RST),
    .d(cap_src),
    .smp(),
    .rise(slow_rise)
  );

  line_sampler #(
    .W(NFAST),
    .PERIOD(FAST_SAMPLE_CYC)
  ) u_fast (
    .clk(CLK),
    .rst(RST),
    .d(cap_src[FAST_BASE +: NFAST]),
    .smp(FAST_IRQ_INPUT),
    .rise(fast_rise)
  );

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // sticky status: a new edge in the clearing cycle survives
  always_comb begin
    next_dir = line_direction_control;
    next_od = line_open_drain_select;
    next_mode = mode;
    next_mask = mask;
    next_fmask = fmask;
    next_stat = stat | slow_rise;
    next_fstat = fstat | fast_rise;
    if (WR) begin
      case (ADDR)
        DIR_OFS: next_dir = WDATA;
        OD_OFS: next_od = WDATA;
        MODE_LO_OFS: next_mode[15:0] = WDATA;
        MODE_HI_OFS: next_mode[31:16] = WDATA;
        STAT_OFS: next_stat = (stat & ~WDATA) | slow_rise;
        MASK_OFS: next_mask = WDATA;
        FSTAT_OFS: next_fstat = (fstat & ~WDATA[7:0]) | fast_rise;
        FMASK_OFS: next_fmask = WDATA[7:0];
        default: begin
          next_dir = line_direction_control;
        end
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = RST_WORD;
    if (RD) begin
      case (ADDR)
        DATA_OFS: next_rdata = cap_src;
        DIR_OFS: next_rdata = line_direction_control;
        OD_OFS: next_rdata = line_open_drain_select;
        MODE_LO_OFS: next_rdata = mode[15:0];
        MODE_HI_OFS: next_rdata = mode[31:16];
        STAT_OFS: next_rdata = stat;
        MASK_OFS: next_rdata = mask;
        FSTAT_OFS: next_rdata = {RST_BYTE, fstat};
        FMASK_OFS: next_rdata = {RST_BYTE, fmask};
        default: next_rdata = RST_WORD;
      endcase
    end
  end

  always_comb begin
    next_cap = cap_src;
    next_t7 = sync2[T7_LINE];
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      line_direction_control <= RST_WORD;
      line_open_drain_select <= RST_WORD;
      mode <= {RST_WORD, RST_WORD};
      stat <= RST_WORD;
      mask <= RST_WORD;
      fstat <= RST_BYTE;
      fmask <= RST_BYTE;
      RDATA <= RST_WORD;
      CAP_IN <= RST_WORD;
      TIMER_SEVEN_COUNT_INPUT <= 1'b0;
    end else begin
      line_direction_control <= next_dir;
      line_open_drain_select <= next_od;
      mode <= next_mode;
      stat <= next_stat;
      mask <= next_mask;
      fstat <= next_fstat;
      fmask <= next_fmask;
      RDATA <= next_rdata;
      CAP_IN <= next_cap;
      TIMER_SEVEN_COUNT_INPUT <= next_t7;
    end
  end

  // level interrupt while any unmasked status bit stands
  assign IRQ = (|(stat & mask)) | (|(fstat & fmask));

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  logic [NLINES-1:0] tog_hit;
  logic [NLINES-1:0] set_hit;
  logic [NLINES-1:0] clr_hit;

  // helper: which lines a trigger should move this cycle
  for (genvar k = 0; k < NLINES; k++) begin : g_hit
    assign tog_hit[k] = !wr_data && CMP_MATCH[k]
      && (g_line[k].m == CMP_TOGGLE || g_line[k].m == CMP_DOUBLE);
    assign set_hit[k] = !wr_data && CMP_MATCH[k]
      && g_line[k].m == CMP_SET_CLR;
    assign clr_hit[k] = !wr_data && !CMP_MATCH[k] && TMR_OVF[k]
      && g_line[k].m == CMP_SET_CLR;
  end

  sequence s_tog;
    |tog_hit;
  endsequence

  sequence s_toggled;
    ((latch ^ $past(latch)) & $past(tog_hit)) == $past(tog_hit);
  endsequence

  property p_dir_float;
    (CAPTURE_COMPARE_CHANNEL_PINS_OE & ~line_direction_control) == '0;
  endproperty
  a_dir_float: assert property (p_dir_float)
    else $error("pin driven while direction is input");

  property p_cpu_wins;
    wr_data && (|trig) |=> latch == $past(WDATA);
  endproperty
  a_cpu_wins: assert property (p_cpu_wins)
    else $error("compare trigger overrode cpu write");

  property p_toggle;
    s_tog |=> s_toggled;
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle mode match did not invert latch");

  property p_set;
    |set_hit |=> (latch & $past(set_hit)) == $past(set_hit);
  endproperty
  a_set: assert property (p_set)
    else $error("set mode match did not set latch");

  property p_clr;
    |clr_hit |=> (latch & $past(clr_hit)) == '0;
  endproperty
  a_clr: assert property (p_clr)
    else $error("timer overflow did not clear latch");

  property p_hold;
    !wr_data && trig == '0 |=> latch == $past(latch);
  endproperty
  a_hold: assert property (p_hold)
    else $error("latch changed without trigger or write");

  property p_capture;
    ##1 CAP_IN == $past(
      (line_direction_control & latch) | (~line_direction_control & sync2));
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture signal not from latch or pin");

  property p_open_drain;
    (CAPTURE_COMPARE_CHANNEL_PINS_OE & line_open_drain_select & latch) == '0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open drain line driven high");

  property p_t7;
    ##2 TIMER_SEVEN_COUNT_INPUT == $past(sync1[T7_LINE], 2);
  endproperty
  a_t7: assert property (p_t7)
    else $error("timer seven input not top pin");

  property p_read;
    RD && ADDR == DIR_OFS |=> RDATA == $past(line_direction_control);
  endproperty
  a_read: assert property (p_read)
    else $error("direction readback wrong");

endmodule : port2_ccio

/* File: dv/ccu_pin_model.sv */
module ccu_pin_model (
  input wire logic CLK,
  input wire logic [15:0] PIN_OUT,
  input wire logic [15:0] PIN_OE,
  output logic [15:0] PIN_IN,
  output logic [15:0] MATCH,
  output logic [15:0] OVF
);
  timeunit 1ns;
  timeprecision 1ps;

  // external driver state, set by the bench
  logic [15:0] ext_en = 16'h0000;
  logic [15:0] ext_val = 16'h0000;

  // ----------------------------------------------------------------
  // pin resolution
  // ----------------------------------------------------------------
  // no contention
  // undriven lines sit at the pull-up, never at a stale value
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (PIN_OE[i]) PIN_IN[i] = PIN_OUT[i];
      else if (ext_en[i]) PIN_IN[i] = ext_val[i];
      else PIN_IN[i] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // compare trigger strobes
  // ----------------------------------------------------------------
  initial begin
    MATCH = 16'h0000;
    OVF = 16'h0000;
  end

  // one-cycle strobe launched just after a rising edge
  task automatic fire(input logic [15:0] m, input logic [15:0] o);
    @(posedge CLK);
    MATCH <= m;
    OVF <= o;
    @(posedge CLK);
    MATCH <= 16'h0000;
    OVF <= 16'h0000;
  endtask : fire
endmodule : ccu_pin_model

/* File: dv/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import port2_pkg::*;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata, pin_in, pin_out, pin_oe, match, ovf, cap_in, rv;
  logic [7:0] fast_irq;
  logic t7, irq;
  int fail_count = 0;
  int samples_checked = 0;

  // ----------------------------------------------------------------
  // clock, design and far side
  // ----------------------------------------------------------------
  initial begin
    forever #2 clk = ~clk;
  end

  port2_ccio uut (
    .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .CAPTURE_COMPARE_CHANNEL_PINS_IN(pin_in),
    .CAPTURE_COMPARE_CHANNEL_PINS_OUT(pin_out),
    .CAPTURE_COMPARE_CHANNEL_PINS_OE(pin_oe), .CMP_MATCH(match),
    .TMR_OVF(ovf), .CAP_IN(cap_in), .FAST_IRQ_INPUT(fast_irq),
    .TIMER_SEVEN_COUNT_INPUT(t7), .IRQ(irq)
  );

  ccu_pin_model p (
    .CLK(clk), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PIN_IN(pin_in),
    .MATCH(match), .OVF(ovf)
  );

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // strobe launched one edge after entry, so calls never collide
  task automatic bus_wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // step off the landing edge so callers see the settled outputs
    #1;
  endtask : bus_wr

  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : bus_rd

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
    bus_rd(a, rv);
    chk(rv, exp);
  endtask : rd_chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #80000;
    fail_count++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_chk(DIR_OFS, RST_WORD);
    rd_chk(OD_OFS, RST_WORD);
    rd_chk(MODE_LO_OFS, RST_WORD);
    // idle lines are inputs, pulled high
    rd_chk(DATA_OFS, 16'hFFFF);
    chk(pin_oe, 16'h0000);
    // push-pull outputs follow the latch
    bus_wr(DIR_OFS, 16'hFFFF);
    bus_wr(DATA_OFS, 16'hA5C3);
    chk(pin_out, 16'hA5C3);
    chk(pin_oe, 16'hFFFF);
    // open drain on low byte only drives zeros
    bus_wr(OD_OFS, 16'h00FF);
    rd_chk(OD_OFS, 16'h00FF);
    chk(pin_oe, 16'hFF3C);
    chk(pin_out, 16'hA500);
    bus_wr(OD_OFS, 16'h0000);
    // toggle on lines 7..0, double on 8, set/clear on 15
    bus_wr(MODE_LO_OFS, 16'h5555);
    bus_wr(MODE_HI_OFS, 16'hC002);
    p.fire(16'h910F, 16'h0000);
    rd_chk(DATA_OFS, 16'hA4CC);
    // overflow clears only the set/clear line
    p.fire(16'h0000, 16'h8001);
    rd_chk(DATA_OFS, 16'h24CC);
    p.fire(16'h8000, 16'h0000);
    rd_chk(DATA_OFS, 16'hA4CC);
    // bus write beats a coinciding trigger
    fork
      bus_wr(DATA_OFS, 16'h1234);
      p.fire(16'h800F, 16'h0000);
    join
    rd_chk(DATA_OFS, 16'h1234);
    // upper byte as inputs: compare still moves the latch, pin stays off
    bus_wr(DIR_OFS, 16'h00FF);
    p.fire(16'h0100, 16'h0000);
    chk(pin_oe, 16'h00FF);
    repeat (4) @(posedge clk);
    // capture sees latch on outputs, pin on inputs
    chk(cap_in, 16'hFF34);
    bus_wr(DIR_OFS, 16'hFFFF);
    rd_chk(DATA_OFS, 16'h1334);
    bus_wr(DIR_OFS, 16'h00FF);
    @(posedge clk);
    p.ext_en <= 16'hFF00;
    p.ext_val <= 16'h0000;
    repeat (120) @(posedge clk);
    chk(cap_in, 16'h0034);
    chk({15'h0000, t7}, 16'h0000);
    bus_wr(STAT_OFS, 16'hFFFF);
    bus_wr(FSTAT_OFS, 16'h00FF);
    bus_wr(MASK_OFS, 16'h0000);
    bus_wr(FMASK_OFS, 16'h0002);
    chk({15'h0000, irq}, 16'h0000);
    // lines 9 and 15 rise
    @(posedge clk);
    p.ext_val <= 16'h8200;
    repeat (12) @(posedge clk);
    chk({8'h00, fast_irq}, 16'h0082);
    chk({15'h0000, t7}, 16'h0001);
    chk({15'h0000, irq}, 16'h0001);
    repeat (60) @(posedge clk);
    rd_chk(STAT_OFS, 16'h8200);
    rd_chk(FSTAT_OFS, 16'h0082);
    // clearing the only unmasked bit drops the request
    bus_wr(FSTAT_OFS, 16'h0002);
    @(posedge clk);
    chk({15'h0000, irq}, 16'h0000);
    rd_chk(FSTAT_OFS, 16'h0080);
    bus_wr(MASK_OFS, 16'h8000);
    @(posedge clk);
    chk({15'h0000, irq}, 16'h0001);
    rd_chk(16'h0000, 16'h0000);
    stop_test();
  end
endmodule : testbench
